// ### hdl/smst_map.svh
// Constants for the safety monitor self-test controller.
// Assumes inclusion by bare name from design and bench files.
`ifndef SMST_MAP_SVH
`define SMST_MAP_SVH
`define SMST_NUM_BUCK 7
`define SMST_NUM_LINREG 4
`define SMST_CLK_HZ 50000000
`define SMST_BLANK_MAX_US 200
`define SMST_BLANK_MAX_CYC ((`SMST_BLANK_MAX_US * (`SMST_CLK_HZ / 1000000)))
`define SMST_STEP_CYC 16
`define SMST_SETTLE_CYC 4
`endif

// ### hdl/smst_pkg.sv
// Types for the safety monitor self-test controller.
// Assumes smst_map.svh is on the include path.
`include "smst_map.svh"
package smst_pkg;
  typedef struct packed {
    logic [`SMST_NUM_BUCK-1:0] buck_ov;
    logic [`SMST_NUM_LINREG-1:0] linreg_ov;
    logic [`SMST_NUM_BUCK-1:0] buck_uv;
    logic [`SMST_NUM_LINREG-1:0] linreg_uv;
  } smst_result_t;
  typedef enum logic [4:0] {
    SMST_IDLE = 5'h01,
    SMST_POWERUP = 5'h02,
    SMST_FORCE = 5'h04,
    SMST_RELEASE = 5'h08,
    SMST_DONE = 5'h10
  } smst_state_t;
endpackage : smst_pkg

// ### hdl/smst_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs come from outside the sys_clk domain.
module smst_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule : smst_sync

// ### hdl/smst_ctrl.sv
// Reference drift monitor and over/under-voltage comparator self-test control.
// Assumes analog comparator and drift outputs are asynchronous levels and the
// register interface lives elsewhere, reaching this block through plain ports.
`include "smst_map.svh"
module smst_ctrl
  import smst_pkg::*;
#(
  parameter int NUM_BUCK = `SMST_NUM_BUCK,
  parameter int NUM_LINREG = `SMST_NUM_LINREG,
  parameter int STEP_CYC = `SMST_STEP_CYC,
  parameter int SETTLE_CYC = `SMST_SETTLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Analog status, asynchronous
  input wire logic reference_drift_raw,
  input wire smst_result_t cmp_state_raw,
  // Power state and configuration
  input wire logic power_up_req,
  input wire logic system_on,
  input wire logic drift_fault_bypass_cfg,
  input wire logic reference_drift_irq_mask,
  input wire logic secure_write_en,
  // Host command strobes, one cycle each
  input wire logic go_wr,
  input wire logic go_wr_secure,
  input wire logic drift_flag_clr,
  input wire logic result_clr,
  input wire logic result_clr_secure,
  // Comparator test drive
  output smst_result_t cmp_force,
  output logic monitor_blank,
  // Power control
  output logic switcher_start_allow,
  output logic power_stage_shutdown,
  output logic power_up_fail,
  output logic power_up_proceed,
  // Status
  output logic reference_drift_sense,
  output logic reference_drift_irq_flag,
  output logic reference_drift_irq,
  output logic selftest_on_demand_go,
  output smst_result_t result
);
  localparam int NBITS = 2 * (NUM_BUCK + NUM_LINREG);
  localparam int BLANK_CYC = `SMST_BLANK_MAX_CYC;

  // Two sync flops delay every comparator reading, so a phase must settle
  // for at least three cycles before its samples mean anything.
  if (NUM_BUCK != `SMST_NUM_BUCK || NUM_LINREG != `SMST_NUM_LINREG) begin : g_count_chk
    $error("Regulator counts must match the result layout.");
  end
  if (STEP_CYC < SETTLE_CYC + 2 || SETTLE_CYC < 3) begin : g_settle_chk
    $error("Step length too short for settling.");
  end
  // The step counter is sixteen bits wide.
  if (STEP_CYC > 65535) begin : g_step_chk
    $error("Step length does not fit the step counter.");
  end
  if (2 * STEP_CYC + 4 > BLANK_CYC) begin : g_blank_chk
    $error("Self-test would exceed the blanking limit.");
  end

  logic drift_s;
  smst_result_t cmp_s;
  // Drift and all comparator levels cross into the clock domain together.
  smst_sync #(.WIDTH(1 + NBITS)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({reference_drift_raw, cmp_state_raw}),
    .sync_out({drift_s, cmp_s})
  );

  // Self-test sequencer state.
  smst_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  logic on_demand_reg, on_demand_next;
  logic go_reg, go_next;
  logic blank_reg, blank_next;
  smst_result_t force_reg, force_next;
  smst_result_t seen_hi_reg, seen_hi_next;
  smst_result_t seen_lo_reg, seen_lo_next;
  smst_result_t result_reg, result_next;
  logic pu_fail_reg, pu_fail_next;
  logic pu_proceed_reg, pu_proceed_next;
  logic pu_drift_reg, pu_drift_next;

  // Drift monitor state.
  logic sense_reg, sense_next;
  logic flag_reg, flag_next;
  logic irq_reg, irq_next;
  logic shutdown_reg, shutdown_next;
  logic allow_reg, allow_next;

  // Plain writes are refused while secure writes are enabled.
  function automatic logic go_accepted(input logic sec_en, input logic wr, input logic wr_sec);
    go_accepted = sec_en ? wr_sec : (wr | wr_sec);
  endfunction : go_accepted

  // A run forces every comparator high for one step and low for the next.
  // Samples taken after the settle time record whether each one followed.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    on_demand_next = on_demand_reg;
    go_next = go_reg;
    blank_next = blank_reg;
    force_next = force_reg;
    seen_hi_next = seen_hi_reg;
    seen_lo_next = seen_lo_reg;
    result_next = result_reg;
    pu_fail_next = pu_fail_reg;
    pu_proceed_next = pu_proceed_reg;
    pu_drift_next = pu_drift_reg;
    // A run's result write below overrides a clear in the same cycle.
    // result clear, plain or secure strobe per secure_write_en
    if (go_accepted(secure_write_en, result_clr, result_clr_secure)) begin
      result_next = '0;
    end
    unique case (state_reg)
      SMST_IDLE: begin
        if (go_accepted(secure_write_en, go_wr, go_wr_secure) && !go_reg) begin
          go_next = 1'b1;
          on_demand_next = 1'b1;
          blank_next = 1'b1;
          state_next = SMST_FORCE;
          phase_next = 1'b0;
          cnt_next = '0;
          seen_hi_next = '0;
          seen_lo_next = '0;
        end else if (power_up_req) begin
          // Power-up runs without blanking; nothing is monitored yet.
          on_demand_next = 1'b0;
          pu_fail_next = 1'b0;
          pu_proceed_next = 1'b0;
          pu_drift_next = 1'b0;
          seen_hi_next = '0;
          seen_lo_next = '0;
          phase_next = 1'b0;
          cnt_next = '0;
          state_next = SMST_POWERUP;
        end
      end
      SMST_POWERUP: begin
        state_next = SMST_FORCE;
      end
      SMST_FORCE: begin
        force_next = phase_reg ? '0 : '1;
        cnt_next = cnt_reg + 16'h0001;
        if (!on_demand_reg && drift_s) begin
          pu_drift_next = 1'b1;
        end
        if (cnt_reg >= 16'(SETTLE_CYC)) begin
          seen_hi_next = phase_reg ? seen_hi_reg : (seen_hi_reg | cmp_s);
          seen_lo_next = phase_reg ? (seen_lo_reg | ~cmp_s) : seen_lo_reg;
        end
        if (cnt_reg == 16'(STEP_CYC - 1)) begin
          cnt_next = '0;
          if (phase_reg) begin
            state_next = SMST_RELEASE;
          end else begin
            phase_next = 1'b1;
          end
        end
      end
      SMST_RELEASE: begin
        force_next = '0;
        result_next = ~(seen_hi_reg & seen_lo_reg);
        state_next = SMST_DONE;
      end
      SMST_DONE: begin
        if (on_demand_reg) begin
          // Blanking drops one cycle before the go bit, so the host never
          // sees go low while fault response is still held off.
          // restore monitoring
          blank_next = 1'b0;
          if (!blank_reg) begin
            go_next = 1'b0;
            state_next = SMST_IDLE;
          end
        end else begin
          pu_fail_next = pu_drift_reg | drift_s;
          pu_proceed_next = !(pu_drift_reg | drift_s);
          state_next = SMST_IDLE;
        end
      end
      default: begin
        state_next = SMST_IDLE;
      end
    endcase
  end

  always_comb begin
    sense_next = drift_s;
    flag_next = (flag_reg & ~drift_flag_clr) | drift_s;
    irq_next = flag_next & ~reference_drift_irq_mask;
    shutdown_next = shutdown_reg;
    // Shutdown stays latched through the rest of the system-on state so a
    // drift that clears again cannot restart the power stages.
    // shutdown unless bypassed
    if (system_on && drift_s && !drift_fault_bypass_cfg) begin
      shutdown_next = 1'b1;
    end else if (!system_on) begin
      shutdown_next = 1'b0;
    end
    // A failed power-up self-test keeps the switchers blocked until the
    // next power-up run clears it.
    // block switcher start
    allow_next = !drift_s && !pu_fail_next;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= SMST_IDLE;
      cnt_reg <= '0;
      phase_reg <= 1'b0;
      on_demand_reg <= 1'b0;
      go_reg <= 1'b0;
      blank_reg <= 1'b0;
      force_reg <= '0;
      seen_hi_reg <= '0;
      seen_lo_reg <= '0;
      result_reg <= '0;
      pu_fail_reg <= 1'b0;
      pu_proceed_reg <= 1'b0;
      pu_drift_reg <= 1'b0;
      sense_reg <= 1'b0;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
      shutdown_reg <= 1'b0;
      allow_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      on_demand_reg <= on_demand_next;
      go_reg <= go_next;
      blank_reg <= blank_next;
      force_reg <= force_next;
      seen_hi_reg <= seen_hi_next;
      seen_lo_reg <= seen_lo_next;
      result_reg <= result_next;
      pu_fail_reg <= pu_fail_next;
      pu_proceed_reg <= pu_proceed_next;
      pu_drift_reg <= pu_drift_next;
      sense_reg <= sense_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      shutdown_reg <= shutdown_next;
      allow_reg <= allow_next;
    end
  end

  assign cmp_force = force_reg;
  assign monitor_blank = blank_reg;
  assign switcher_start_allow = allow_reg;
  assign power_stage_shutdown = shutdown_reg;
  assign power_up_fail = pu_fail_reg;
  assign power_up_proceed = pu_proceed_reg;
  assign reference_drift_sense = sense_reg;
  assign reference_drift_irq_flag = flag_reg;
  assign reference_drift_irq = irq_reg;
  assign selftest_on_demand_go = go_reg;
  assign result = result_reg;
endmodule : smst_ctrl

// ### bench/smst_ctrl_sva.sv
// Port checker for the self-test controller.
// Assumes one clock and a synchronous active-high reset.
`include "smst_map.svh"
module smst_ctrl_chk
  import smst_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic system_on,
  input wire logic drift_fault_bypass_cfg,
  input wire logic reference_drift_irq_mask,
  input wire logic drift_flag_clr,
  input wire logic monitor_blank,
  input wire logic switcher_start_allow,
  input wire logic power_stage_shutdown,
  input wire logic reference_drift_sense,
  input wire logic reference_drift_irq_flag,
  input wire logic reference_drift_irq,
  input wire logic selftest_on_demand_go
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLANK_MAX = `SMST_BLANK_MAX_CYC;
  int blank_cnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !monitor_blank) begin
      blank_cnt_reg <= 0;
    end else begin
      blank_cnt_reg <= blank_cnt_reg + 1;
    end
  end
  irq_has_flag_a: assert property (reference_drift_irq |-> reference_drift_irq_flag)
    else $error("drift irq without flag");
  irq_unmasked_a: assert property (reference_drift_irq_flag && $past(reference_drift_irq_flag)
    && !reference_drift_irq_mask && !$past(reference_drift_irq_mask) |-> reference_drift_irq)
    else $error("unmasked drift irq missing");
  flag_sticky_a: assert property (reference_drift_irq_flag && !drift_flag_clr
    |=> reference_drift_irq_flag) else $error("drift flag lost");
  sense_flag_a: assert property (reference_drift_sense |-> ##[0:2] reference_drift_irq_flag)
    else $error("drift flag not set");
  drift_block_a: assert property (reference_drift_sense && $past(reference_drift_sense)
    |-> !switcher_start_allow) else $error("start allowed during drift");
  drift_stop_a: assert property (system_on && !drift_fault_bypass_cfg && reference_drift_sense
    |-> ##[0:2] power_stage_shutdown) else $error("no shutdown on drift");
  go_blank_a: assert property ($rose(selftest_on_demand_go) |-> monitor_blank)
    else $error("test runs unblanked");
  blank_owner_a: assert property (monitor_blank |-> selftest_on_demand_go)
    else $error("blank outside a test");
  blank_bound_a: assert property (blank_cnt_reg < BLANK_MAX)
    else $error("blank too long");
  restore_first_a: assert property ($fell(selftest_on_demand_go)
    |-> $past(monitor_blank, 2) && !$past(monitor_blank)) else $error("go cleared early");
  cover property ($fell(selftest_on_demand_go));
  cover property ($rose(power_stage_shutdown));
  cover property ($rose(reference_drift_irq));
endmodule : smst_ctrl_chk

bind smst_ctrl smst_ctrl_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .system_on(system_on),
  .drift_fault_bypass_cfg(drift_fault_bypass_cfg), .drift_flag_clr(drift_flag_clr),
  .reference_drift_irq_mask(reference_drift_irq_mask), .monitor_blank(monitor_blank),
  .switcher_start_allow(switcher_start_allow), .power_stage_shutdown(power_stage_shutdown),
  .reference_drift_sense(reference_drift_sense), .reference_drift_irq(reference_drift_irq),
  .reference_drift_irq_flag(reference_drift_irq_flag),
  .selftest_on_demand_go(selftest_on_demand_go));

// ### bench/smst_cmp_model.sv
// Comparator and reference model facing the self-test controller.
// Assumes the bench drives the stuck masks and the drift level.
module smst_cmp_model
  import smst_pkg::*;
(
  // Clock and bench control
  input wire logic sys_clk,
  input wire smst_result_t stuck_hi,
  input wire smst_result_t stuck_lo,
  input wire logic slow,
  input wire logic drift,
  // Device side
  input wire smst_result_t cmp_force,
  output smst_result_t cmp_state_raw,
  output logic reference_drift_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  smst_result_t lag_reg;
  smst_result_t cmp_now;
  // Stuck comparators ignore the forced level.
  assign cmp_now = (cmp_force | stuck_hi) & ~stuck_lo;
  always_ff @(posedge sys_clk) lag_reg <= cmp_now;
  assign cmp_state_raw = slow ? lag_reg : cmp_now;
  assign reference_drift_raw = drift;
endmodule : smst_cmp_model

// ### bench/test_safety_monitor_selftest_ctrl.sv
// Random and corner tests of the self-test controller.
// Assumes the comparator model stands in for the analog side.
module test_safety_monitor_selftest_ctrl
  import smst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, sys_on, byp, mask, sec, drift, slow, draw;
  logic blank, allow, shut, pfail, pgo, sense, flag, irq, go;
  logic [5:0] stb;
  smst_result_t hi, lo, frc, raw, res, mh, ml;
  logic [31:0] lfsr;
  int miscompares, n_checks;
  smst_ctrl dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reference_drift_raw(draw),
    .cmp_state_raw(raw), .power_up_req(stb[5]), .system_on(sys_on),
    .drift_fault_bypass_cfg(byp), .reference_drift_irq_mask(mask), .secure_write_en(sec),
    .go_wr(stb[0]), .go_wr_secure(stb[1]), .drift_flag_clr(stb[2]), .result_clr(stb[3]),
    .result_clr_secure(stb[4]), .cmp_force(frc), .monitor_blank(blank),
    .switcher_start_allow(allow), .power_stage_shutdown(shut), .power_up_fail(pfail),
    .power_up_proceed(pgo), .reference_drift_sense(sense), .reference_drift_irq_flag(flag),
    .reference_drift_irq(irq), .selftest_on_demand_go(go), .result(res));
  smst_cmp_model cmp_u (.sys_clk(sys_clk), .stuck_hi(hi), .stuck_lo(lo), .slow(slow),
    .drift(drift), .cmp_force(frc), .cmp_state_raw(raw), .reference_drift_raw(draw));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic smst_result_t expect_fail(input smst_result_t h, input smst_result_t l);
    return h | l;
  endfunction : expect_fail
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic strobe(input logic [5:0] v);
    @(posedge sys_clk);
    stb <= v;
    @(posedge sys_clk);
    stb <= 6'h00;
  endtask : strobe
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // The host starts a run only when safe and reads the flags after it.
  task automatic selftest(input logic [5:0] v, input smst_result_t h, input smst_result_t l);
    int i;
    @(posedge sys_clk);
    hi <= h;
    lo <= l;
    slow <= lfsr[5];
    strobe(v);
    cyc(3);
    check(frc, 32'h3fffff);
    check(blank, {31'h0, ~v[5]});
    i = 0;
    while (i < 60 && (go !== 1'b0 || (v[5] && pgo !== 1'b1 && pfail !== 1'b1))) begin
      cyc(1);
      i++;
    end
    check(go, 1'b0);
    check(res, expect_fail(h, l));
    check(frc, 32'h0);
    check(blank, 32'h0);
  endtask : selftest
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    {sys_rst, sys_on, byp, mask, sec, drift, slow, stb} = 13'h1000;
    hi = '0;
    lo = '0;
    lfsr = 32'h20bb;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      mh = lfsr[21:0] & ~lfsr[31:10];
      ml = lfsr[31:10] & ~lfsr[21:0];
      if (k < 3) begin
        mh = (k == 1) ? '1 : '0;
        ml = (k == 2) ? '1 : '0;
      end
      selftest(k[0] ? 6'h02 : 6'h01, mh, ml);
    end
    @(posedge sys_clk);
    sec <= 1'b1;
    strobe(6'h01);
    cyc(4);
    check(go, 1'b0);
    strobe(6'h08);
    cyc(3);
    check(res, expect_fail(mh, ml));
    strobe(6'h10);
    cyc(3);
    check(res, 32'h0);
    selftest(6'h02, 22'h2a0c35, 22'h01500a);
    selftest(6'h20, 22'h000011, '0);
    check({pgo, pfail}, 2'b10);
    @(posedge sys_clk);
    sys_on <= 1'b1;
    byp <= 1'b1;
    drift <= 1'b1;
    cyc(6);
    check({sense, flag, irq, shut}, 4'b1110);
    @(posedge sys_clk);
    mask <= 1'b1;
    drift <= 1'b0;
    cyc(5);
    check({sense, flag, irq}, 3'b010);
    strobe(6'h04);
    cyc(2);
    check(flag, 1'b0);
    @(posedge sys_clk);
    byp <= 1'b0;
    drift <= 1'b1;
    cyc(6);
    check({shut, allow}, 2'b10);
    @(posedge sys_clk);
    sys_on <= 1'b0;
    byp <= 1'b1;
    selftest(6'h20, 22'h000011, '0);
    check({pfail, pgo, allow}, 3'b100);
    check(shut, 1'b0);
    @(posedge sys_clk);
    sec <= 1'b0;
    strobe(6'h08);
    cyc(2);
    check(res, 32'h0);
    stop_test();
  end
endmodule : test_safety_monitor_selftest_ctrl
